/* File: pcrb_defs.svh */
// Offsets, field positions, reset values and timing constants of the loop configuration bank
`ifndef PCRB_DEFS_SVH
`define PCRB_DEFS_SVH

// Register address width and register count
`define PCRB_ADDR_W        12
`define PCRB_REG_N         5

// Register offsets
`define PCRB_ADDR_TAG_LO   12'h005
`define PCRB_ADDR_TAG_HI   12'h006
`define PCRB_ADDR_LOOP     12'h010
`define PCRB_ADDR_RDIV_LO  12'h011
`define PCRB_ADDR_RDIV_HI  12'h012

// Reset values
`define PCRB_RST_TAG_LO    8'h00
`define PCRB_RST_TAG_HI    8'h00
`define PCRB_RST_LOOP      8'h7D
`define PCRB_RST_RDIV_LO   8'h01
`define PCRB_RST_RDIV_HI   8'h00

// Storage masks; unmasked bits are not stored and read as zero
`define PCRB_MASK_FULL     8'hFF
`define PCRB_MASK_RDIV_HI  8'h3F

// Loop control field positions
`define PCRB_LOOP_POL_BIT  7
`define PCRB_LOOP_CUR_MSB  6
`define PCRB_LOOP_CUR_LSB  4
`define PCRB_LOOP_CPM_MSB  3
`define PCRB_LOOP_CPM_LSB  2
`define PCRB_LOOP_PWR_MSB  1
`define PCRB_LOOP_PWR_LSB  0

// Upper reference divider field width
`define PCRB_RDIV_HI_W     6

// Read data latency in clock cycles
`define PCRB_RD_LAT        1

`endif

/* File: pcrb_pkg.sv */
// Types shared by the loop configuration bank
package pcrb_pkg;

  // Loop power modes
  typedef enum logic [1:0] {
    PCRB_PWR_NORMAL = 2'h0,
    PCRB_PWR_ASYNC  = 2'h1,
    PCRB_PWR_UNUSED = 2'h2,
    PCRB_PWR_SYNC   = 2'h3
  } pcrb_loop_pwr_t;

  // Charge pump modes
  typedef enum logic [1:0] {
    PCRB_CPM_HIZ    = 2'h0,
    PCRB_CPM_SOURCE = 2'h1,
    PCRB_CPM_SINK   = 2'h2,
    PCRB_CPM_NORMAL = 2'h3
  } pcrb_cp_mode_t;

endpackage

/* File: pcrb_reg8.sv */
// One 8-bit configuration register with a reset value and a storage mask
`timescale 1ns/10ps
`default_nettype none

module pcrb_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK      = 8'hFF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       we_in,
  input  wire logic [7:0] wdata_in,
  output var  logic [7:0] q_out
);

  // Store masked write data; unstored bits stay zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_out <= RESET_VAL & MASK;
    end else if (we_in) begin
      q_out <= wdata_in & MASK;
    end
  end

endmodule

`default_nettype wire

/* File: pcrb_top.sv */
// Loop configuration register bank: version tag, loop control and reference divider
// Notes on behaviour
// - Address 0x005 holds version tag low byte, read/write, reset 0x00.
// - Address 0x006 holds version tag high byte, read/write, reset 0x00.
// - Version tag bytes are storage only; they steer no other output.
// - Loop control bit 7 picks detector polarity; 0 positive at reset.
// - Loop control bits 1:0 set power mode; only 00 lets loop run.
// - Reference divider is 14 bits assembled from two registers.
// - Address 0x011 holds divider bits 7:0, reset 0x01.
// - Address 0x012 holds divider bits 13:8 in low six bits, reset 0x00.
`timescale 1ns/10ps
`default_nettype none
`include "pcrb_defs.svh"

module pcrb_top
  import pcrb_pkg::*;
(
  input  wire logic                     CLK_IN,
  input  wire logic                     RST_N_IN,
  input  wire logic                     WR_EN_IN,
  input  wire logic                     RD_EN_IN,
  input  wire logic [`PCRB_ADDR_W-1:0]  ADDR_IN,
  input  wire logic [7:0]               WDATA_IN,
  output var  logic [7:0]               RDATA_OUT,
  output var  logic                     RVALID_OUT,
  output var  logic                     PFD_NEG_OUT,
  output var  logic [2:0]               CP_CURRENT_OUT,
  output var  logic [1:0]               CP_MODE_OUT,
  output var  logic [1:0]               LOOP_PWR_OUT,
  output var  logic                     LOOP_RUN_OUT,
  output var  logic [13:0]              REF_DIV_OUT
);

  localparam int REG_N    = `PCRB_REG_N;
  localparam int IDX_TLO  = 0;
  localparam int IDX_THI  = 1;
  localparam int IDX_LOOP = 2;
  localparam int IDX_RLO  = 3;
  localparam int IDX_RHI  = 4;

  // Address, reset value and storage mask of each register
  localparam logic [`PCRB_ADDR_W-1:0] REG_ADDR [REG_N] = '{
    `PCRB_ADDR_TAG_LO, `PCRB_ADDR_TAG_HI, `PCRB_ADDR_LOOP,
    `PCRB_ADDR_RDIV_LO, `PCRB_ADDR_RDIV_HI};
  localparam logic [7:0] REG_RST [REG_N] = '{
    `PCRB_RST_TAG_LO, `PCRB_RST_TAG_HI, `PCRB_RST_LOOP,
    `PCRB_RST_RDIV_LO, `PCRB_RST_RDIV_HI};
  localparam logic [7:0] REG_MASK [REG_N] = '{
    `PCRB_MASK_FULL, `PCRB_MASK_FULL, `PCRB_MASK_FULL,
    `PCRB_MASK_FULL, `PCRB_MASK_RDIV_HI};

  logic [7:0] reg_q [REG_N];
  logic [7:0] next_rdata;
  logic       next_run;
  logic [1:0] pwr_field;

  // Address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [`PCRB_ADDR_W-1:0] addr, input int idx);
    addr_hit = (addr == REG_ADDR[idx]);
  endfunction

  // Any mapped register address; used by the checks on unmapped accesses
  function automatic logic addr_mapped(input logic [`PCRB_ADDR_W-1:0] addr);
    addr_mapped = 1'b0;
    for (int i = 0; i < REG_N; i++) begin
      if (addr_hit(addr, i)) begin
        addr_mapped = 1'b1;
      end
    end
  endfunction

  // Register storage, one cell per mapped address
  for (genvar g = 0; g < REG_N; g++) begin : g_reg
    pcrb_reg8 #(
      .RESET_VAL (REG_RST[g]),
      .MASK      (REG_MASK[g])
    ) u_reg (
      .clk_in   (CLK_IN),
      .rst_n_in (RST_N_IN),
      .we_in    (WR_EN_IN && addr_hit(ADDR_IN, g)),
      .wdata_in (WDATA_IN),
      .q_out    (reg_q[g])
    );
  end

  // Read mux; unmapped addresses and unstored bits read zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < REG_N; i++) begin
      if (addr_hit(ADDR_IN, i)) begin
        next_rdata = reg_q[i];
      end
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT  <= 8'h00;
      RVALID_OUT <= 1'b0;
    end else begin
      RVALID_OUT <= RD_EN_IN;
      if (RD_EN_IN) begin
        RDATA_OUT <= next_rdata;
      end
    end
  end

  // Loop control fields drive the loop directly from storage
  assign PFD_NEG_OUT    = reg_q[IDX_LOOP][`PCRB_LOOP_POL_BIT];
  assign CP_CURRENT_OUT = reg_q[IDX_LOOP][`PCRB_LOOP_CUR_MSB:`PCRB_LOOP_CUR_LSB];
  assign CP_MODE_OUT    = reg_q[IDX_LOOP][`PCRB_LOOP_CPM_MSB:`PCRB_LOOP_CPM_LSB];
  assign LOOP_PWR_OUT   = reg_q[IDX_LOOP][`PCRB_LOOP_PWR_MSB:`PCRB_LOOP_PWR_LSB];
  assign pwr_field      = LOOP_PWR_OUT;

  // Reference divider assembled from both halves; tag bytes feed nothing here
  assign REF_DIV_OUT = {reg_q[IDX_RHI][`PCRB_RDIV_HI_W-1:0], reg_q[IDX_RLO]};

  // Run enable only in normal power mode; every power-down code stops it
  always_comb begin
    unique case (pcrb_loop_pwr_t'(pwr_field))
      PCRB_PWR_NORMAL: next_run = 1'b1;
      PCRB_PWR_ASYNC:  next_run = 1'b0;
      PCRB_PWR_UNUSED: next_run = 1'b0;
      PCRB_PWR_SYNC:   next_run = 1'b0;
    endcase
  end

  // Run flag lags the power field by one cycle
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      LOOP_RUN_OUT <= 1'b0;
    end else begin
      LOOP_RUN_OUT <= next_run;
    end
  end

  // Checks on the register bank
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  a_tag_low_write: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_LO && RD_EN_IN == 1'b0
    ##1 !(WR_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_LO)
    ##1 RD_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_LO
    |=> RVALID_OUT && RDATA_OUT == $past(WDATA_IN, 3))
    else $error("Tag low byte did not read back as written");

  a_tag_high_write: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_HI
    ##1 !(WR_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_HI)
    ##1 RD_EN_IN && ADDR_IN == `PCRB_ADDR_TAG_HI
    |=> RDATA_OUT == $past(WDATA_IN, 3))
    else $error("Tag high byte did not read back as written");

  a_tag_isolated: assert property (
    WR_EN_IN && (ADDR_IN == `PCRB_ADDR_TAG_LO || ADDR_IN == `PCRB_ADDR_TAG_HI)
    |=> $stable(REF_DIV_OUT) && $stable(PFD_NEG_OUT) && $stable(CP_CURRENT_OUT)
        && $stable(CP_MODE_OUT) && $stable(LOOP_PWR_OUT))
    else $error("Tag write disturbed a loop setting");

  a_polarity_write: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_LOOP
    |=> PFD_NEG_OUT == $past(WDATA_IN[7]))
    else $error("Polarity bit not taken from loop control write");

  a_loop_reset: assert property (
    $rose(RST_N_IN)
    |-> !PFD_NEG_OUT && CP_CURRENT_OUT == 3'h7 && CP_MODE_OUT == 2'h3
        && LOOP_PWR_OUT == 2'h1 && !LOOP_RUN_OUT && REF_DIV_OUT == 14'h0001)
    else $error("Loop settings wrong after reset");

  a_run_power: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_LOOP
    |=> ##1 LOOP_RUN_OUT == ($past(WDATA_IN[1:0], 2) == 2'h0))
    else $error("Run flag does not follow power mode");

  a_rdiv_low: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_RDIV_LO
    |=> REF_DIV_OUT[7:0] == $past(WDATA_IN) && $stable(REF_DIV_OUT[13:8]))
    else $error("Divider low byte not applied");

  a_rdiv_high: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_RDIV_HI
    |=> REF_DIV_OUT[13:8] == $past(WDATA_IN[5:0]) && $stable(REF_DIV_OUT[7:0]))
    else $error("Divider high bits not applied");

  a_rdiv_hi_read: assert property (
    RD_EN_IN && ADDR_IN == `PCRB_ADDR_RDIV_HI
    |=> RDATA_OUT[7:6] == 2'h0 && RDATA_OUT[5:0] == $past(REF_DIV_OUT[13:8]))
    else $error("Divider high register upper bits not zero");

  a_cp_mode_write: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_LOOP
    |=> CP_MODE_OUT == $past(WDATA_IN[3:2]))
    else $error("Charge pump mode not applied");

  a_cp_current_write: assert property (
    WR_EN_IN && ADDR_IN == `PCRB_ADDR_LOOP
    |=> CP_CURRENT_OUT == $past(WDATA_IN[6:4]))
    else $error("Charge pump current not applied");

  a_read_answer: assert property (
    RD_EN_IN
    |=> RVALID_OUT)
    else $error("Read strobe not answered one cycle later");

  a_valid_pulse: assert property (
    !RD_EN_IN
    |=> !RVALID_OUT)
    else $error("Read valid raised without a read");

  a_rdata_hold: assert property (
    !RD_EN_IN
    |=> $stable(RDATA_OUT))
    else $error("Read data changed without a read");

  a_unmapped_read: assert property (
    RD_EN_IN && !addr_mapped(ADDR_IN)
    |=> RVALID_OUT && RDATA_OUT == 8'h00)
    else $error("Unmapped address did not read as zero");

  a_unmapped_write: assert property (
    WR_EN_IN && !addr_mapped(ADDR_IN)
    |=> $stable(REF_DIV_OUT) && $stable(PFD_NEG_OUT) && $stable(CP_CURRENT_OUT)
        && $stable(CP_MODE_OUT) && $stable(LOOP_PWR_OUT))
    else $error("Unmapped write disturbed a loop setting");

endmodule

`default_nettype wire

/* File: pcrb_host.sv */
// Host model that drives the register access port of the loop configuration bank
`timescale 1ns/10ps
`default_nettype none

module pcrb_host #(
  parameter bit EXT_OSC = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        rvalid_in,
  output var  logic        wr_en_out,
  output var  logic        rd_en_out,
  output var  logic [11:0] addr_out,
  output var  logic [7:0]  wdata_out
);
  // Idle port at time zero
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 12'hFFF;
    wdata_out = 8'hFF;
  end

  // One write per call; address and data are scrambled once released
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (!EXT_OSC && a == 12'h010) v[7] = 1'b0;
    @(negedge clk_in);
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = v;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~v;
  endtask

  // One read per call; the answer is taken one cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_in);
    rd_en_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    d = rdata_in;
    ok = rvalid_in;
    rd_en_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the loop configuration register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        clk;
  logic        rst_n;
  logic        wr_en;
  logic        rd_en;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        pfd;
  logic [2:0]  cur;
  logic [1:0]  mode;
  logic [1:0]  pwr;
  logic        run;
  logic [13:0] rdiv;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [11:0] ra [5] = '{12'h005, 12'h006, 12'h011, 12'h012, 12'h007};
  logic [7:0]  rw [5] = '{8'hA5, 8'h5A, 8'hFE, 8'hFF, 8'h55};
  logic [7:0]  rx [5] = '{8'hA5, 8'h5A, 8'hFE, 8'h3F, 8'h00};
  logic [7:0]  lc [4] = '{8'h00, 8'h95, 8'h6A, 8'hFF};

  pcrb_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
    .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
    .PFD_NEG_OUT(pfd), .CP_CURRENT_OUT(cur), .CP_MODE_OUT(mode), .LOOP_PWR_OUT(pwr),
    .LOOP_RUN_OUT(run), .REF_DIV_OUT(rdiv));

  pcrb_host u_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

  // Clock and hang guard
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(d), 16'(exp));
  endtask

  // Reset values at the ports and through reads
  task automatic defaults();
    chk(16'({pfd, cur, mode, pwr}), 16'h007D);
    chk(16'(run), 16'h0000);
    chk(16'(rdiv), 16'h0001);
    rdchk(12'h005, 8'h00);
    rdchk(12'h006, 8'h00);
    rdchk(12'h010, 8'h7D);
    rdchk(12'h011, 8'h01);
    rdchk(12'h012, 8'h00);
  endtask

  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence: reset, table rows, loop control codes, reset in mid-run
  initial begin
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    defaults();
    for (int i = 0; i < 5; i++) begin
      u_host.wr(ra[i], rw[i]);
      rdchk(ra[i], rx[i]);
    end
    chk(16'(rdiv), 16'h3FFE);
    chk(16'({pfd, cur, mode, pwr}), 16'h007D);
    u_host.wr(12'h005, 8'h3C);
    chk(16'({rdiv, run}), 16'h7FFC);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(12'h010, lc[i]);
      chk(16'({pfd, cur, mode, pwr}), 16'(lc[i]));
      @(negedge clk);
      chk(16'(run), 16'(lc[i][1:0] == 2'h0));
      rdchk(12'h010, lc[i]);
    end
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    defaults();
    results();
  end
endmodule
`default_nettype wire
